// ==== rtl/dpclk_cfg.svh ====
// constants for the channel datapath clock router: offsets, fields, resets
// assumes inclusion by bare name from the design modules and the testbench
`ifndef DPCLK_CFG_SVH
`define DPCLK_CFG_SVH

// register byte offsets on the plain register port
`define DPCLK_OFF_MODE 8'h00
`define DPCLK_OFF_SRC 8'h04
`define DPCLK_OFF_STAT 8'h08
`define DPCLK_OFF_ERR 8'h0c

// reset values: non-bonded, transmit and receive, adjacent first pll
`define DPCLK_MODE_RST 10'h008
`define DPCLK_SRC_RST 8'h00
`define DPCLK_ERR_RST 4'h0

// sticky error bit positions
`define DPCLK_ERR_SRC 0
`define DPCLK_ERR_RXBOND 1
`define DPCLK_ERR_RXRMF 2
`define DPCLK_ERR_BOND 3

// pll input indices on the high/low speed clock vectors
`define DPCLK_PLL_ADJ_FIRST 2'h0
`define DPCLK_PLL_ADJ_SECOND 2'h1
`define DPCLK_PLL_BEYOND_LO 2'h2
`define DPCLK_PLL_BEYOND_HI 2'h3

// lane masks and pointer owner patterns
`define DPCLK_MASK_X2 4'h3
`define DPCLK_MASK_X4 4'hf
`define DPCLK_OWN_X1 8'he4
`define DPCLK_OWN_X2 8'he0
`define DPCLK_OWN_X4 8'h00

`endif

// ==== rtl/dpclk_pkg.sv ====
// types shared by the datapath clock router and its helpers
// assumes the constants header sits beside it
package dpclk_pkg;

  // channel bonding width
  typedef enum logic [1:0] {BOND_X1, BOND_X2, BOND_X4, BOND_RSVD} bond_t;

  // channel operation mode
  typedef enum logic [1:0] {OP_TX_ONLY, OP_RX_ONLY, OP_TX_RX, OP_OFF} op_t;

  // per-channel clock source code as software writes it
  typedef enum logic [1:0] {
    SRC_ADJ_FIRST, SRC_ADJ_SECOND, SRC_BEYOND, SRC_RSVD
  } src_code_t;

  // configuration word, same layout as the mode register
  typedef struct packed {
    logic bond_sel;
    logic cdr_sel;
    logic lpkg;
    logic bdes;
    logic bser;
    logic rmf;
    op_t op;
    bond_t bond;
  } cfg_t;

  // clocks delivered to one channel's pma and pcs sub-blocks
  typedef struct packed {
    logic ser;
    logic enc;
    logic bser_rd;
    logic txpcf_rd;
    logic cdr;
    logic des;
    logic align;
    logic rmf_wr;
    logic rmf_rd;
    logic dec;
    logic bdes_wr;
    logic border;
    logic rxpcf_wr;
  } ch_clk_t;

endpackage

// ==== rtl/half_rate_div.sv ====
// divide-by-two stage for a phase compensation fifo side clock
// assumes the clock level is sampled synchronously on clock_i
`timescale 1ns/1ps
`include "dpclk_cfg.svh"

module half_rate_div
(
  // system
  input wire logic clock_i,
  input wire logic srst_i,
  // clock level in and halving enable
  input wire logic clk_lvl_i,
  input wire logic half_i,
  // value the fifo side clock takes at the next edge
  output logic out_next_o
);

  logic prev_reg; // last sampled level, for rise detection
  logic prev_next;
  logic tog_reg; // toggles once per input rise
  logic tog_next;

  // toggle keeps running even when not halving, so a shared divider
  // never needs a restart when bonding is switched in
  always_comb
  begin
    prev_next = clk_lvl_i;
    tog_next = tog_reg;
    if (clk_lvl_i && !prev_reg)
    begin
      tog_next = !tog_reg;
    end
    out_next_o = half_i ? tog_next : clk_lvl_i;
  end

  // state registers
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      prev_reg <= 1'b0;
      tog_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      tog_reg <= tog_next;
    end
  end

endmodule

// ==== rtl/dpclk_cfg_check.sv ====
// legalises the software configuration into an effective one
// assumes raw register words in, purely combinational
`timescale 1ns/1ps
`include "dpclk_cfg.svh"

module dpclk_cfg_check
  import dpclk_pkg::*;
(
  // raw register contents
  input wire logic [9:0] mode_i,
  input wire logic [7:0] src_i,
  // effective configuration
  output cfg_t eff_o,
  output logic [3:0] bonded_o,
  output logic [7:0] idx_o,
  // configuration faults seen this cycle
  output logic [3:0] err_o
);

  // maps a source code to a pll index; unusable codes fall back
  function automatic logic [1:0] pick_pll(input logic [1:0] code,
                                          input logic upper_pair,
                                          input logic beyond_ok);
    logic [1:0] idx;
    idx = `DPCLK_PLL_ADJ_FIRST;
    if (code == SRC_ADJ_SECOND)
    begin
      idx = `DPCLK_PLL_ADJ_SECOND;
    end
    else if (code == SRC_BEYOND && beyond_ok)
    begin
      idx = upper_pair ? `DPCLK_PLL_BEYOND_HI : `DPCLK_PLL_BEYOND_LO;
    end
    return idx;
  endfunction

  always_comb
  begin
    cfg_t raw;
    logic [1:0] code;
    logic ok;
    raw = cfg_t'(mode_i);
    eff_o = raw;
    err_o = 4'h0;
    bonded_o = 4'h0;
    idx_o = 8'h00;
    code = 2'h0;
    ok = 1'b0;
    // reserved bonding code runs the lanes unbonded
    if (raw.bond == BOND_RSVD)
    begin
      eff_o.bond = BOND_X1;
      err_o[`DPCLK_ERR_BOND] = 1'b1;
    end
    // receive-only lanes are clocked by their own recovered clocks
    if (raw.op == OP_RX_ONLY && eff_o.bond != BOND_X1)
    begin
      eff_o.bond = BOND_X1;
      err_o[`DPCLK_ERR_RXBOND] = 1'b1;
    end
    if (raw.op == OP_RX_ONLY && raw.rmf)
    begin
      eff_o.rmf = 1'b0;
      err_o[`DPCLK_ERR_RXRMF] = 1'b1;
    end
    else if (raw.op != OP_TX_RX)
    begin
      eff_o.rmf = 1'b0;
    end
    // two-lane bonding only on lanes 0 and 1
    case (eff_o.bond)
      BOND_X2: bonded_o = `DPCLK_MASK_X2;
      BOND_X4: bonded_o = `DPCLK_MASK_X4;
      default: bonded_o = 4'h0;
    endcase
    // beyond-adjacent plls only unbonded in large package
    for (int k = 0; k < 4; k++)
    begin
      code = src_i[2*k +: 2];
      ok = eff_o.lpkg && !bonded_o[k];
      idx_o[2*k +: 2] = pick_pll(code, k > 1, ok);
      if (code[1] && !(code == SRC_BEYOND && ok))
      begin
        err_o[`DPCLK_ERR_SRC] = 1'b1;
      end
    end
  end

endmodule

// ==== rtl/transceiver_datapath_clocking.sv ====
// routes pll and recovered clocks to the four lanes of a transceiver
// block and to the fabric parallel clock outputs.
// assumes all clock levels arrive sampled on clock_i, and software keeps
// the configuration still while traffic flows.
//
// Notes on behaviour
// - cdr clocks from one adjacent pll only
// - no cdr clock beyond adjacent plls
// - unbonded lanes own clocks and fifo pointers
// - bonded lanes share low-speed clock and pointers
// - two-lane bonding only lanes 0 and 1
// - four-lane bonding uses all four lanes
// - large package unbonded may use farther plls
// - transmit high-speed clock drives the serializer
// - transmit low-speed clocks encoder, byte serializer, fifo
// - byte serializer halves transmit fifo read clock
// - transmit low-speed clock goes to fabric
// - receive-only never uses rate match fifo
// - recovered clocks drive deserializer and receive pcs
// - byte deserializer halves receive fifo write clock
// - receive-only recovered clock goes to fabric
// - combined mode supports rate match on or off
// - combined without rate match clocks like receive-only
// - rate match splits recovered and transmit clocks
// - rate match with deserializer halves transmit clock
// - with rate match transmit parallel clock serves receive capture too
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "dpclk_cfg.svh"

module transceiver_datapath_clocking
  import dpclk_pkg::*;
(
  // system
  input wire logic clock_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // pll clocks: index 0/1 adjacent, 2/3 farther plls
  input wire logic [3:0] pll_hs_i,
  input wire logic [3:0] pll_ls_i,
  input wire logic [1:0] pll_cdr_i,
  // recovered clocks from each lane's cdr unit
  input wire logic [3:0] rec_hs_i,
  input wire logic [3:0] rec_ls_i,
  // lane clocks
  output ch_clk_t [3:0] ch_clk_o,
  // fabric clocks and fifo control ownership
  output logic [3:0] tx_par_clk_o,
  output logic [3:0] rx_par_clk_o,
  output logic bonded_clk_o,
  output logic [7:0] pcf_owner_o
);

  // software registers
  logic [9:0] mode_reg; // raw mode word
  logic [9:0] mode_next;
  logic [7:0] src_reg; // per-lane source codes
  logic [7:0] src_next;
  logic [3:0] err_reg; // sticky configuration faults
  logic [3:0] err_next;
  logic [31:0] rdata_reg; // read data, valid the cycle after a read
  logic [31:0] rdata_next;

  // effective configuration
  cfg_t eff;
  logic [3:0] bonded;
  logic [7:0] idx;
  logic [3:0] err_live;
  logic tx_on; // transmit side clocked
  logic rx_on; // receive side clocked

  // per-lane clock picks
  logic [3:0] hs_pick;
  logic [3:0] tx_ls;
  logic [3:0] rec_later; // clock of receive blocks after rate match
  logic [3:0] txpcf_in;
  logic [3:0] rxpcf_in;
  logic [3:0] txpcf_div;
  logic [3:0] rxpcf_div;
  logic bond_ls; // common bonded low-speed path

  // clock output registers
  ch_clk_t [3:0] ch_reg;
  ch_clk_t [3:0] ch_next;
  logic [3:0] tx_par_reg;
  logic [3:0] tx_par_next;
  logic [3:0] rx_par_reg;
  logic [3:0] rx_par_next;
  logic bond_clk_reg;
  logic bond_clk_next;
  logic [7:0] owner_reg;
  logic [7:0] owner_next;

  // legalise what software wrote
  dpclk_cfg_check u_check
  (
    .mode_i(mode_reg),
    .src_i(src_reg),
    .eff_o(eff),
    .bonded_o(bonded),
    .idx_o(idx),
    .err_o(err_live)
  );

  // one divider per lane and direction; bonded lanes read lane 0's transmit divider, and its receive divider only with rate match
  for (genvar g = 0; g < 4; g++)
  begin : g_div
    half_rate_div u_txdiv
    (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .clk_lvl_i(txpcf_in[g]),
      .half_i(eff.bser),
      .out_next_o(txpcf_div[g])
    );
    half_rate_div u_rxdiv
    (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .clk_lvl_i(rxpcf_in[g]),
      .half_i(eff.bdes),
      .out_next_o(rxpcf_div[g])
    );
  end

  // register file: next values and read mux
  always_comb
  begin
    mode_next = mode_reg;
    src_next = src_reg;
    rdata_next = 32'h0000_0000;
    // faults set even in the cycle software clears them
    err_next = err_reg | err_live;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `DPCLK_OFF_MODE: mode_next = reg_wdata_i[9:0];
        `DPCLK_OFF_SRC: src_next = reg_wdata_i[7:0];
        `DPCLK_OFF_ERR: err_next = (err_reg & ~reg_wdata_i[3:0]) | err_live;
        default: mode_next = mode_reg; // unmapped writes are dropped
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `DPCLK_OFF_MODE: rdata_next = 32'(mode_reg);
        `DPCLK_OFF_SRC: rdata_next = 32'(src_reg);
        `DPCLK_OFF_STAT: rdata_next = 32'({eff.rmf, owner_reg, bonded});
        `DPCLK_OFF_ERR: rdata_next = 32'(err_reg);
        default: rdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // register file state
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      mode_reg <= `DPCLK_MODE_RST;
      src_reg <= `DPCLK_SRC_RST;
      err_reg <= `DPCLK_ERR_RST;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      mode_reg <= mode_next;
      src_reg <= src_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // clock source selection per lane
  always_comb
  begin
    tx_on = (eff.op == OP_TX_ONLY) || (eff.op == OP_TX_RX);
    rx_on = (eff.op == OP_RX_ONLY) || (eff.op == OP_TX_RX);
    // bonded path takes an adjacent pll only
    bond_ls = pll_ls_i[{1'b0, eff.bond_sel}];
    for (int k = 0; k < 4; k++)
    begin
      hs_pick[k] = pll_hs_i[idx[2*k +: 2]];
      tx_ls[k] = bonded[k] ? bond_ls : pll_ls_i[idx[2*k +: 2]];
      // receive side chooses its clock by rate match use
      // without rate match the recovered clock runs it all
      // with rate match later blocks run on transmit clock
      rec_later[k] = eff.rmf ? tx_ls[k] : rec_ls_i[k];
      txpcf_in[k] = tx_on & tx_ls[k];
      rxpcf_in[k] = rx_on & rec_later[k];
    end
  end

  // lane clock fan-out and fabric clocks
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      ch_next[k].ser = tx_on & hs_pick[k];
      // one low-speed clock for the transmit pcs
      ch_next[k].enc = tx_on & tx_ls[k];
      ch_next[k].bser_rd = tx_on & tx_ls[k];
      // halved read side when the byte serializer runs
      // bonded lanes follow lane 0 fifo control
      ch_next[k].txpcf_rd = bonded[k] ? txpcf_div[0] : txpcf_div[k];
      // all cdr units share one adjacent pll
      // only the two adjacent pll inputs reach a cdr
      ch_next[k].cdr = rx_on & pll_cdr_i[eff.cdr_sel];
      // recovered clocks drive deserializer and aligner
      ch_next[k].des = rx_on & rec_hs_i[k];
      ch_next[k].align = rx_on & rec_ls_i[k];
      // rate match written by recovered, read by transmit
      ch_next[k].rmf_wr = rx_on & eff.rmf & rec_ls_i[k];
      ch_next[k].rmf_rd = rx_on & eff.rmf & tx_ls[k];
      ch_next[k].dec = rx_on & rec_later[k];
      ch_next[k].bdes_wr = rx_on & rec_later[k];
      ch_next[k].border = rx_on & rec_later[k];
      // halved write side when the byte deserializer runs
      // same halving on the transmit clock with rate match
      // a shared receive divider only makes sense on a common clock
      ch_next[k].rxpcf_wr = (bonded[k] && eff.rmf) ? rxpcf_div[0]
                                                   : rxpcf_div[k];
      // transmit low-speed clock out to the fabric
      // with rate match fabric captures on it as well
      tx_par_next[k] = tx_on & tx_ls[k];
      // recovered low-speed clock out when no rate match
      rx_par_next[k] = rx_on & !eff.rmf & rec_ls_i[k];
    end
    bond_clk_next = (|bonded) & tx_on & bond_ls;
    // unbonded lanes own their fifo pointers
    // bonded lanes share lane 0 pointers
    case (eff.bond)
      BOND_X2: owner_next = `DPCLK_OWN_X2;
      BOND_X4: owner_next = `DPCLK_OWN_X4;
      default: owner_next = `DPCLK_OWN_X1;
    endcase
  end

  // clock output registers; all lanes low in reset
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ch_reg <= '0;
      tx_par_reg <= 4'h0;
      rx_par_reg <= 4'h0;
      bond_clk_reg <= 1'b0;
      owner_reg <= `DPCLK_OWN_X1;
    end
    else
    begin
      ch_reg <= ch_next;
      tx_par_reg <= tx_par_next;
      rx_par_reg <= rx_par_next;
      bond_clk_reg <= bond_clk_next;
      owner_reg <= owner_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign ch_clk_o = ch_reg;
  assign tx_par_clk_o = tx_par_reg;
  assign rx_par_clk_o = rx_par_reg;
  assign bonded_clk_o = bond_clk_reg;
  assign pcf_owner_o = owner_reg;

  // checks on the routing

  a_cdr_one_pll: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (ch_clk_o[0].cdr == ch_clk_o[1].cdr)
      && (ch_clk_o[2].cdr == ch_clk_o[3].cdr)
      && (ch_clk_o[0].cdr == ch_clk_o[3].cdr))
    else $error("cdr clocks differ between lanes");

  a_cdr_adjacent_only: assert property (
    @(posedge clock_i) disable iff (srst_i)
    rx_on ##1 ch_clk_o[2].cdr |-> $past(pll_cdr_i) != 2'h0)
    else $error("cdr clock without an adjacent pll");

  a_unbonded_own_ptr: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (bonded == 4'h0) |=> pcf_owner_o == `DPCLK_OWN_X1)
    else $error("unbonded lane lost its own fifo control");

  a_bonded_shared_clk: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (eff.bond == BOND_X4) && tx_on |=> (tx_par_clk_o == 4'hf)
      || (tx_par_clk_o == 4'h0))
    else $error("bonded lanes see different low-speed clocks");

  a_x2_lane_pair: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (eff.bond == BOND_X2) |=> pcf_owner_o == `DPCLK_OWN_X2)
    else $error("two-lane bonding not on lanes 0 and 1");

  a_beyond_pll_gate: assert property (
    @(posedge clock_i) disable iff (srst_i)
    idx[7] |-> eff.lpkg && !bonded[3])
    else $error("farther pll used where not allowed");

  a_ser_hs_follow: assert property (
    @(posedge clock_i) disable iff (srst_i)
    tx_on |=> ch_clk_o[1].ser == $past(hs_pick[1]))
    else $error("serializer clock not from its pll");

  a_txfifo_half_rate: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (eff.bser && (bonded == 4'h0))[*2] ##0 !txpcf_in[2]
      |=> $stable(ch_clk_o[2].txpcf_rd))
    else $error("halved fifo read clock moved without an input rise");

  a_rx_only_no_rmf: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (eff.op == OP_RX_ONLY) |=> !ch_clk_o[0].rmf_wr && !ch_clk_o[0].rmf_rd
      && !ch_clk_o[3].rmf_wr)
    else $error("rate match clocked in receive-only mode");

  a_rx_par_recovered: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (eff.op == OP_RX_ONLY) |=> rx_par_clk_o[1] == $past(rec_ls_i[1]))
    else $error("receive parallel clock not the recovered clock");

  a_rmf_dec_on_tx: assert property (
    @(posedge clock_i) disable iff (srst_i)
    eff.rmf && rx_on |=> (ch_clk_o[2].dec == $past(tx_ls[2]))
      && (ch_clk_o[2].align == $past(rec_ls_i[2])))
    else $error("rate match split of receive clocks broken");

  a_tx_par_is_enc: assert property (
    @(posedge clock_i) disable iff (srst_i)
    tx_par_clk_o[3] == ch_clk_o[3].enc)
    else $error("transmit parallel clock differs from encoder clock");

endmodule

// ==== verification/pll_clock_model.sv ====
// behavioural source of the pll and recovered clock levels
// assumes the system clock and the router's reset drive it
`timescale 1ns/1ps

module pll_clock_model
(
  // system
  input wire logic clock_i,
  input wire logic srst_i,
  // update the levels only every other cycle
  input wire logic slow_i,
  // sampled clock levels toward the router
  output logic [3:0] pll_hs_o,
  output logic [3:0] pll_ls_o,
  output logic [1:0] pll_cdr_o,
  output logic [3:0] rec_hs_o,
  output logic [3:0] rec_ls_o
);
  // shift sequence gives every level its own irregular rhythm
  logic [15:0] seq_reg;
  // skip flag used while running slow
  logic hold_reg;

  // advance the sequence, half as often when slow
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      seq_reg <= 16'hace1;
      hold_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= slow_i & ~hold_reg;
      if (!hold_reg)
        seq_reg <= {seq_reg[14:0],
          seq_reg[15] ^ seq_reg[13] ^ seq_reg[12] ^ seq_reg[10]};
    end
  end

  // distinct bits per source so a wrong selection shows
  assign pll_hs_o = seq_reg[3:0];
  assign pll_ls_o = seq_reg[7:4];
  assign pll_cdr_o = seq_reg[9:8];
  assign rec_hs_o = seq_reg[13:10];
  assign rec_ls_o = {seq_reg[15:14], seq_reg[1:0] ^ seq_reg[15:14]};
endmodule

// ==== verification/transceiver_datapath_clocking_tb.sv ====
// self-checking bench for the datapath clock router
// assumes the pll clock model drives every clock level input
`timescale 1ns/1ps
`include "dpclk_cfg.svh"

module transceiver_datapath_clocking_tb
  import dpclk_pkg::*;
();
  // system and register port
  logic clock_i;
  logic srst_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] rdata;
  // clock levels from the model
  logic slow;
  logic [3:0] pll_hs, pll_ls, rec_hs, rec_ls;
  logic [1:0] pll_cdr;
  // router outputs
  ch_clk_t [3:0] ch;
  logic [3:0] txp, rxp;
  logic bclk;
  logic [7:0] own;
  // snapshots from the previous falling edge
  logic [3:0] ph, pl, rh, rl;
  logic [1:0] pc;
  ch_clk_t [3:0] pch;
  // configuration as last written
  logic [9:0] mode;
  logic [7:0] src;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  pll_clock_model i_pll_clock_model (.clock_i(clock_i), .srst_i(srst_i),
    .slow_i(slow), .pll_hs_o(pll_hs), .pll_ls_o(pll_ls),
    .pll_cdr_o(pll_cdr), .rec_hs_o(rec_hs), .rec_ls_o(rec_ls));

  transceiver_datapath_clocking i_transceiver_datapath_clocking (
    .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .pll_hs_i(pll_hs), .pll_ls_i(pll_ls),
    .pll_cdr_i(pll_cdr), .rec_hs_i(rec_hs), .rec_ls_i(rec_ls),
    .ch_clk_o(ch), .tx_par_clk_o(txp), .rx_par_clk_o(rxp),
    .bonded_clk_o(bclk), .pcf_owner_o(own));

  // 10 MHz system clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    chk("read", e, rdata);
  endtask

  // lanes that share the bonded path; receive-only never bonds
  function automatic logic [3:0] bmask();
    if (mode[3:2] == 2'h1)
      return 4'h0;
    if (mode[1:0] == 2'h1)
      return 4'h3;
    if (mode[1:0] == 2'h2)
      return 4'hf;
    return 4'h0;
  endfunction

  // pll index of a lane's transmit clocks; bonded lanes take the low
  // speed clock from the common path but keep their own high speed pick
  function automatic logic [1:0] lane_pll(input int l, input logic ls);
    logic [1:0] c;
    logic [3:0] bm;
    c = src[2*l +: 2];
    bm = bmask();
    if (ls && bm[l])
      return {1'b0, mode[9]};
    if (c == 2'h1)
      return 2'h1;
    if (c == 2'h2 && mode[7] && !bm[l])
      return (l < 2) ? 2'h2 : 2'h3;
    return 2'h0;
  endfunction

  // static setup before traffic is judged
  task automatic cfg(input logic [9:0] m, input logic [7:0] s);
    wr(`DPCLK_OFF_MODE, {22'h0, m});
    wr(`DPCLK_OFF_SRC, {24'h0, s});
    wr(`DPCLK_OFF_ERR, 32'h0000_000f);
    mode = m;
    src = s;
  endtask

  // compare every routed level against last cycle's inputs
  task automatic watch(input int n);
    logic [1:0] i, j;
    logic [3:0] bm;
    logic tx, rx, rm, e;
    tx = mode[3:2] == 2'h0 || mode[3:2] == 2'h2;
    rx = mode[3:2] == 2'h1 || mode[3:2] == 2'h2;
    rm = mode[4] && mode[3:2] == 2'h2;
    bm = bmask();
    for (int k = 0; k <= n; k++)
    begin
      @(negedge clock_i);
      if (k > 0)
      begin
        for (int l = 0; l < 4; l++)
        begin
          i = lane_pll(l, 1'b1);
          j = lane_pll(l, 1'b0);
          e = rm ? pl[i] : rl[l];
          if (tx)
          begin
            chk("ser", ph[j], ch[l].ser);
            chk("enc", pl[i], ch[l].enc);
            chk("bser_rd", pl[i], ch[l].bser_rd);
            chk("tx_par", pl[i], txp[l]);
            if (mode[5])
              chk("txpcf", ch[l].enc & ~pch[l].enc,
                ch[l].txpcf_rd ^ pch[l].txpcf_rd);
            else
              chk("txpcf", ch[l].enc, ch[l].txpcf_rd);
            if (bm[l])
              chk("txpcf_sh", ch[0].txpcf_rd, ch[l].txpcf_rd);
          end
          else
            chk("tx_off", 4'h0,
              {ch[l].ser, ch[l].enc, ch[l].bser_rd, txp[l]});
          if (rx)
          begin
            chk("cdr", pc[mode[8]], ch[l].cdr);
            chk("des", rh[l], ch[l].des);
            chk("align", rl[l], ch[l].align);
            chk("dec", e, ch[l].dec);
            chk("bdes_wr", e, ch[l].bdes_wr);
            chk("border", e, ch[l].border);
            chk("rx_par", rm ? 1'b0 : rl[l], rxp[l]);
            if (rm)
            begin
              chk("rmf_wr", rl[l], ch[l].rmf_wr);
              chk("rmf_rd", pl[i], ch[l].rmf_rd);
            end
            else
              chk("rmf_off", 2'h0, {ch[l].rmf_wr, ch[l].rmf_rd});
            if (mode[6])
              chk("rxpcf", ch[l].dec & ~pch[l].dec,
                ch[l].rxpcf_wr ^ pch[l].rxpcf_wr);
            else
              chk("rxpcf", ch[l].dec, ch[l].rxpcf_wr);
          end
          else
            chk("rx_off", 7'h00,
              {ch[l].cdr, ch[l].des, ch[l].align, ch[l].dec,
              ch[l].bdes_wr, ch[l].border, rxp[l]});
        end
        e = tx && bm != 4'h0 && pl[mode[9]];
        chk("bonded", e, bclk);
        chk("owner", bmask() == 4'hf ? 8'h00 :
          bmask() == 4'h3 ? 8'he0 : 8'he4, own);
      end
      ph = pll_hs;
      pl = pll_ls;
      rh = rec_hs;
      rl = rec_ls;
      pc = pll_cdr;
      pch = ch;
    end
  endtask

  // defaults, unmapped place, plain transmit and receive
  task automatic t_reset();
    @(negedge clock_i);
    chk("owner_rst", 8'he4, own);
    rd(`DPCLK_OFF_MODE, 32'h0000_0008);
    rd(`DPCLK_OFF_STAT, 32'h0000_0e40);
    wr(8'h10, 32'h0000_0155);
    rd(8'h10, 32'h0000_0000);
    rd(`DPCLK_OFF_MODE, 32'h0000_0008);
    mode = 10'h008;
    src = 8'h00;
    watch(20);
  endtask

  // transmit only, byte serializer, farther plls
  task automatic t_tx();
    cfg(10'h020, 8'h44);
    rd(`DPCLK_OFF_ERR, 32'h0000_0000);
    watch(30);
    cfg(10'h0a0, 8'ha2);
    rd(`DPCLK_OFF_ERR, 32'h0000_0000);
    watch(20);
    cfg(10'h020, 8'he2);
    rd(`DPCLK_OFF_ERR, 32'h0000_0001);
    watch(10);
  endtask

  // receive only asking for bonding and rate match
  task automatic t_rx();
    cfg(10'h155, 8'h00);
    rd(`DPCLK_OFF_ERR, 32'h0000_0006);
    rd(`DPCLK_OFF_STAT, 32'h0000_0e40);
    watch(30);
    // lanes switched off: every routed clock but the fifo side and rate match ones must stay low
    cfg(10'h00c, 8'h00);
    rd(`DPCLK_OFF_ERR, 32'h0000_0000);
    watch(10);
  endtask

  // rate match with byte deserializer, slow sources too
  task automatic t_rmf();
    cfg(10'h058, 8'h14);
    rd(`DPCLK_OFF_STAT, 32'h0000_1e40);
    watch(20);
    slow <= 1'b1;
    watch(20);
    slow <= 1'b0;
  endtask

  // four and two lane bonding, reserved bond code
  task automatic t_bond();
    cfg(10'h22a, 8'h00);
    rd(`DPCLK_OFF_STAT, 32'h0000_000f);
    watch(30);
    cfg(10'h209, 8'h55);
    rd(`DPCLK_OFF_STAT, 32'h0000_0e03);
    watch(20);
    cfg(10'h259, 8'h55);
    rd(`DPCLK_OFF_STAT, 32'h0000_1e03);
    watch(20);
    cfg(10'h00b, 8'h00);
    rd(`DPCLK_OFF_ERR, 32'h0000_0008);
    watch(10);
  endtask

  // main sequence: reset six cycles, then every scenario
  initial
  begin
    srst_i = 1'b1;
    slow = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_tx();
    t_rx();
    t_rmf();
    t_bond();
    end_of_test();
  end
endmodule
